// ---- hw/ppi_defs.svh ----
// Purpose: Offsets, field positions, masks and reset values of the pad pull inhibit registers.
// Assumes: Register indices are word indices; the APB byte address is four times the index.
// Notes:   Definitions only.
`ifndef PPI_DEFS_SVH
`define PPI_DEFS_SVH

// Register indices as printed; word indices, not byte addresses, so the byte address is index times four.
`define PPI_IDX_CTRL_B        16'h1c18
`define PPI_IDX_CTRL_C        16'h1c19
`define PPI_ADDR_CTRL_B       18'h07060
`define PPI_ADDR_CTRL_C       18'h07064

// Field positions in the second register.
`define PPI_B_IRQ1_BIT        14
`define PPI_B_IRQ0_BIT        13
`define PPI_B_RSTPIN_BIT      12
`define PPI_B_EMU_BIT         11
`define PPI_B_TDI_BIT         10
`define PPI_B_TMS_BIT         9
`define PPI_B_TCK_BIT         8
`define PPI_B_ADDR_LSB        0
`define PPI_B_ADDR_MSB        5

// Field positions in the third register.
`define PPI_C_PAR_LSB         2
`define PPI_C_PAR_MSB         15

// Writable masks and reset values.
`define PPI_B_WMASK           16'h7f3f
`define PPI_B_RESET           16'h603f
`define PPI_C_WMASK           16'hfffc
`define PPI_C_RESET           16'hfffc

`endif

// ---- hw/ppi_pkg.sv ----
// Purpose: Types shared by the pad pull inhibit register bank.
// Assumes: Constants live in ppi_defs.svh.
// Notes:   Pull controls travel as one packed struct.
package ppi_pkg;

    // Pad pull-control outputs; a 1 turns the pull resistor off.
    typedef struct packed {
        logic        irq1_pullup_off;
        logic        irq0_pullup_off;
        logic        rst_pin_pullup_off;
        logic        emulation_pair_pullup_off;
        logic        test_data_in_pullup_off;
        logic        test_mode_sel_pullup_off;
        logic        test_clk_pullup_off;
        logic [5:0]  addr_pulldown_off;
        logic [15:2] par_port_pulldown_off;
    } ppi_pad_ctrl_t;

endpackage

// ---- hw/ppi_regs.sv ----
// Purpose: APB slave holding two pad pull inhibit registers that drive pad pull controls.
// Assumes: One clock, asynchronous active-high reset, APB master on the same clock.
// Notes:   Zero wait states; unmapped addresses read zero and answer with pslverr.
// Notes on behaviour
// - Bit 14 of register B turns off interrupt-1 pull-up; resets to 1.
// - Bit 13 of register B turns off interrupt-0 pull-up; resets to 1.
// - Bit 12 of register B turns off reset pin pull-up; resets to 0.
// - Bit 11 of register B turns off both emulation pin pull-ups; resets 0.
// - Bits 10, 9, 8 turn off test data, mode, clock pull-ups; reset 0.
// - Bits 5..0 turn off address pins 20..15 pull-downs; reset 1.
// - Register B decodes at four times its index; bits 15, 7, 6 read zero.
// - Register C decodes at four times its index; bits 15..2 writable reset 1, 1..0 zero.
// - Bit k of register C turns off parallel port pin k pull-down.
`timescale 1ns/10ps
`include "ppi_defs.svh"

module ppi_regs
    import ppi_pkg::*;
#(
    parameter int ADDR_W = 18
)(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output ppi_pad_ctrl_t          pad_ctrl
);

    logic [15:0]   ctrl_b_reg;
    logic [15:0]   ctrl_c_reg;
    logic [15:0]   ctrl_b_next;
    logic [15:0]   ctrl_c_next;
    logic          hit_b;
    logic          hit_c;
    logic          setup;
    logic          access_reg;

    // Merge write data into a register under the byte strobes and the writable mask.
    function automatic logic [15:0] merge(input logic [15:0] cur, input logic [31:0] wd,
                                          input logic [3:0] st, input logic [15:0] wmask);
        logic [15:0] lanes;
        lanes = {{8{st[1]}}, {8{st[0]}}} & wmask;
        merge = (cur & ~lanes) | (wd[15:0] & lanes);
    endfunction

    // Address decode; only a setup cycle starts a transfer.
    assign hit_b = (paddr == `PPI_ADDR_CTRL_B);
    assign hit_c = (paddr == `PPI_ADDR_CTRL_C);
    assign setup = psel && !penable;

    // Next values; reserved positions are masked out so they stay zero.
    always_comb
    begin
        ctrl_b_next = ctrl_b_reg;
        ctrl_c_next = ctrl_c_reg;
        if (setup && pwrite && hit_b)
        begin
            ctrl_b_next = merge(ctrl_b_reg, pwdata, pstrb, `PPI_B_WMASK);
        end
        if (setup && pwrite && hit_c)
        begin
            ctrl_c_next = merge(ctrl_c_reg, pwdata, pstrb, `PPI_C_WMASK);
        end
    end

    // The write lands at the edge that ends the setup cycle; the access phase then completes at once.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_b_reg <= `PPI_B_RESET;
            ctrl_c_reg <= `PPI_C_RESET;
        end
        else
        begin
            ctrl_b_reg <= ctrl_b_next;
            ctrl_c_reg <= ctrl_c_next;
        end
    end

    // Bus answer: pready, prdata and pslverr are registered during setup for the access phase.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            access_reg <= 1'b0;
            pready     <= 1'b0;
            prdata     <= 32'h0000_0000;
            pslverr    <= 1'b0;
        end
        else
        begin
            access_reg <= setup;
            pready     <= setup;
            pslverr    <= setup && !hit_b && !hit_c;
            if (setup && !pwrite && hit_b)
            begin
                prdata <= {16'h0000, ctrl_b_reg & `PPI_B_WMASK};
            end
            else if (setup && !pwrite && hit_c)
            begin
                prdata <= {16'h0000, ctrl_c_reg & `PPI_C_WMASK};
            end
            else
            begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // Pad controls follow the registered next value, so outputs are flops equal to the registers.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pad_ctrl <= '{irq1_pullup_off: 1'b1, irq0_pullup_off: 1'b1, addr_pulldown_off: 6'h3f,
                          par_port_pulldown_off: 14'h3fff, default: 1'b0};
        end
        else
        begin
            pad_ctrl.irq1_pullup_off           <= ctrl_b_next[`PPI_B_IRQ1_BIT];
            pad_ctrl.irq0_pullup_off           <= ctrl_b_next[`PPI_B_IRQ0_BIT];
            pad_ctrl.rst_pin_pullup_off        <= ctrl_b_next[`PPI_B_RSTPIN_BIT];
            pad_ctrl.emulation_pair_pullup_off <= ctrl_b_next[`PPI_B_EMU_BIT];
            pad_ctrl.test_data_in_pullup_off   <= ctrl_b_next[`PPI_B_TDI_BIT];
            pad_ctrl.test_mode_sel_pullup_off  <= ctrl_b_next[`PPI_B_TMS_BIT];
            pad_ctrl.test_clk_pullup_off       <= ctrl_b_next[`PPI_B_TCK_BIT];
            pad_ctrl.addr_pulldown_off         <= ctrl_b_next[`PPI_B_ADDR_MSB:`PPI_B_ADDR_LSB];
            pad_ctrl.par_port_pulldown_off     <= ctrl_c_next[`PPI_C_PAR_MSB:`PPI_C_PAR_LSB];
        end
    end

    // Pull-up outputs always mirror bits 14..8 of register B.
    a_pad_b_mirror: assert property (
        @(posedge clk) disable iff (rst)
        {pad_ctrl.irq1_pullup_off, pad_ctrl.irq0_pullup_off, pad_ctrl.rst_pin_pullup_off,
         pad_ctrl.emulation_pair_pullup_off, pad_ctrl.test_data_in_pullup_off,
         pad_ctrl.test_mode_sel_pullup_off, pad_ctrl.test_clk_pullup_off}
        == ctrl_b_reg[14:8]
    )
        else $error("Pull-up outputs differ from register B.");

    // Interrupt-1 pull-up control follows its own bit.
    a_irq1_pad: assert property (
        @(posedge clk) disable iff (rst)
        pad_ctrl.irq1_pullup_off == ctrl_b_reg[`PPI_B_IRQ1_BIT]
    )
        else $error("Interrupt-1 pull-up output differs from its bit.");

    // Interrupt-0 pull-up control follows its own bit.
    a_irq0_pad: assert property (
        @(posedge clk) disable iff (rst)
        pad_ctrl.irq0_pullup_off == ctrl_b_reg[`PPI_B_IRQ0_BIT]
    )
        else $error("Interrupt-0 pull-up output differs from its bit.");

    // Reset pin pull-up control follows its own bit.
    a_rst_pin_pad: assert property (
        @(posedge clk) disable iff (rst)
        pad_ctrl.rst_pin_pullup_off == ctrl_b_reg[`PPI_B_RSTPIN_BIT]
    )
        else $error("Reset pin pull-up output differs from its bit.");

    // One bit serves both emulation pins, so a single output carries it.
    a_emu_pad: assert property (
        @(posedge clk) disable iff (rst)
        pad_ctrl.emulation_pair_pullup_off == ctrl_b_reg[`PPI_B_EMU_BIT]
    )
        else $error("Emulation pull-up output differs from its bit.");

    // Test data input pull-up control follows its own bit.
    a_tdi_pad: assert property (
        @(posedge clk) disable iff (rst)
        pad_ctrl.test_data_in_pullup_off == ctrl_b_reg[`PPI_B_TDI_BIT]
    )
        else $error("Test data pull-up output differs from its bit.");

    // Test mode select pull-up control follows its own bit.
    a_tms_pad: assert property (
        @(posedge clk) disable iff (rst)
        pad_ctrl.test_mode_sel_pullup_off == ctrl_b_reg[`PPI_B_TMS_BIT]
    )
        else $error("Test mode pull-up output differs from its bit.");

    // Test clock pull-up control follows its own bit.
    a_tck_pad: assert property (
        @(posedge clk) disable iff (rst)
        pad_ctrl.test_clk_pullup_off == ctrl_b_reg[`PPI_B_TCK_BIT]
    )
        else $error("Test clock pull-up output differs from its bit.");

    // Address pin pull-downs follow the low field of register B.
    a_addr_mirror: assert property (
        @(posedge clk) disable iff (rst)
        pad_ctrl.addr_pulldown_off == ctrl_b_reg[5:0]
    )
        else $error("Address pull-down outputs differ from register B.");

    // Parallel port pull-downs follow register C bit for bit.
    a_par_mirror: assert property (
        @(posedge clk) disable iff (rst)
        pad_ctrl.par_port_pulldown_off == ctrl_c_reg[15:2]
    )
        else $error("Parallel port outputs differ from register C.");

    // Reserved places of register B never hold a one.
    a_b_reserved_zero: assert property (
        @(posedge clk) disable iff (rst)
        (ctrl_b_reg & ~`PPI_B_WMASK) == 16'h0000
    )
        else $error("Register B reserved bits not zero.");

    // Reserved places of register C never hold a one.
    a_c_reserved_zero: assert property (
        @(posedge clk) disable iff (rst)
        ctrl_c_reg[1:0] == 2'b00
    )
        else $error("Register C reserved bits not zero.");

    // Both registers carry their documented values on the first edge after reset.
    a_reset_values: assert property (
        @(posedge clk) disable iff (rst)
        $fell(rst) |-> ctrl_b_reg == `PPI_B_RESET && ctrl_c_reg == `PPI_C_RESET
    )
        else $error("Register values after reset are wrong.");

    // A write with the upper strobe lands in the upper field of register B.
    a_b_write_lands: assert property (
        @(posedge clk) disable iff (rst)
        (setup && pwrite && hit_b && pstrb[1]) |=> ctrl_b_reg[14:8] == $past(pwdata[14:8])
    )
        else $error("Register B write did not take effect.");

    // A write with the lower strobe lands in the lower field of register C.
    a_c_write_lands: assert property (
        @(posedge clk) disable iff (rst)
        (setup && pwrite && hit_c && pstrb[0]) |=> ctrl_c_reg[7:2] == $past(pwdata[7:2])
    )
        else $error("Register C write did not take effect.");

    // A read of register B answers at once with its reserved places zero.
    a_read_answer: assert property (
        @(posedge clk) disable iff (rst)
        (setup && !pwrite && hit_b) |=> pready && prdata[31:16] == 16'h0000 && prdata[15] == 1'b0
        && prdata[7:6] == 2'b00
    )
        else $error("Register B read answer wrong.");

    // A read of register C returns the value it held during setup.
    a_read_c_answer: assert property (
        @(posedge clk) disable iff (rst)
        (setup && !pwrite && hit_c) |=> pready && prdata[31:16] == 16'h0000
        && prdata[15:2] == $past(ctrl_c_reg[15:2]) && prdata[1:0] == 2'b00
    )
        else $error("Register C read answer wrong.");

    // Nothing but a setup cycle may change either register.
    a_hold_no_write: assert property (
        @(posedge clk) disable iff (rst)
        !(setup && pwrite) |=> $stable(ctrl_b_reg) && $stable(ctrl_c_reg)
    )
        else $error("Register changed without a write.");

    // A write to an unmapped word leaves both registers alone.
    a_unmapped_ignored: assert property (
        @(posedge clk) disable iff (rst)
        (setup && pwrite && !hit_b && !hit_c) |=> $stable(ctrl_b_reg) && $stable(ctrl_c_reg)
    )
        else $error("Unmapped write changed a register.");

    // Every setup is answered in the very next cycle; the master relies on no wait state.
    a_pready_answer: assert property (
        @(posedge clk) disable iff (rst)
        setup |=> pready
    )
        else $error("Setup cycle was not answered.");

    // Ready is a single pulse; outside an access phase it stays low.
    a_pready_idle: assert property (
        @(posedge clk) disable iff (rst)
        !setup |=> !pready
    )
        else $error("Ready high outside an access phase.");

    // The error response marks exactly the unmapped words.
    a_slverr_decode: assert property (
        @(posedge clk) disable iff (rst)
        setup |=> pslverr == $past(!hit_b && !hit_c)
    )
        else $error("Error response does not match the decode.");

    // Read data is zero unless a read was set up, so stale values never leak.
    a_prdata_idle: assert property (
        @(posedge clk) disable iff (rst)
        !(setup && !pwrite) |=> prdata == 32'h0000_0000
    )
        else $error("Read data not zero outside a read.");

endmodule

// ---- sim/pad_pull_inhibit_regs_tb.sv ----
// Purpose: Self-checking bench for the pad pull inhibit register bank.
// Assumes: Zero-wait APB slave on clk; registers sit at word index times four.
// Notes:   Reference images of both registers live here and follow every write.
`timescale 1ns/10ps
`include "ppi_defs.svh"

module pad_pull_inhibit_regs_tb
    import ppi_pkg::*;
;
    logic           clk, rst, psel, penable, pwrite, er;
    logic [17:0]    paddr;
    logic [31:0]    pwdata, prdata, rd;
    logic [3:0]     pstrb;
    logic           pready, pslverr;
    ppi_pad_ctrl_t  pad_ctrl;
    wire logic [26:0] pad_bits;
    logic [15:0]    mb, mc;
    int             err_total = 0, total_checks = 0, cycles = 0;

    assign pad_bits = pad_ctrl;

    ppi_regs #(.ADDR_W(18)) ppi_regs_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pad_ctrl(pad_ctrl));

    // Free-running 200 MHz clock.
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Guard against a slave that never answers; the full run needs well under this.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_total++;
            stop_test();
        end
    end

    task stop_test();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Pad outputs follow the register images bit for bit, 1 meaning pull off.
    function automatic logic [31:0] pad_exp();
        return {5'h0, mb[14:8], mb[5:0], mc[15:2]};
    endfunction

    // One APB transfer; the request is held until pready is seen high at an edge.
    task apb(input logic w, input logic [17:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1)
        begin
            err_total++;
            stop_test();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Write, update the reference with strobes and writable masks, then check response and pads.
    task wr(input logic [17:0] a, input logic [15:0] d, input logic [3:0] s);
        logic [15:0] m;
        m = {{8{s[1]}}, {8{s[0]}}};
        apb(1'b1, a, {16'h0, d}, s);
        if (a == `PPI_ADDR_CTRL_B)
            mb = (mb & ~(m & 16'h7f3f)) | (d & m & 16'h7f3f);
        else if (a == `PPI_ADDR_CTRL_C)
            mc = (mc & ~(m & 16'hfffc)) | (d & m & 16'hfffc);
        chk({31'h0, er}, {31'h0, !(a == `PPI_ADDR_CTRL_B || a == `PPI_ADDR_CTRL_C)});
        chk({5'h0, pad_bits}, pad_exp());
    endtask

    task rdc(input logic [17:0] a, input logic [15:0] e);
        apb(1'b0, a, 32'h0, 4'h0);
        chk(rd, {16'h0, e});
        chk({31'h0, er}, {31'h0, !(a == `PPI_ADDR_CTRL_B || a == `PPI_ADDR_CTRL_C)});
    endtask

    // Reset values of both registers and of every pad control.
    task t_reset();
        rdc(`PPI_ADDR_CTRL_B, 16'h603f);
        rdc(`PPI_ADDR_CTRL_C, 16'hfffc);
        chk({5'h0, pad_bits}, pad_exp());
        $display("test reset done");
    endtask

    // Walk a single one through every bit, reserved places included, then all ones.
    task t_walk();
        for (int i = 0; i < 16; i++)
        begin
            wr(`PPI_ADDR_CTRL_B, 16'h1 << i, 4'hf);
            rdc(`PPI_ADDR_CTRL_B, mb);
            wr(`PPI_ADDR_CTRL_C, 16'h1 << i, 4'hf);
            rdc(`PPI_ADDR_CTRL_C, mc);
        end
        wr(`PPI_ADDR_CTRL_B, 16'hffff, 4'hf);
        rdc(`PPI_ADDR_CTRL_B, mb);
        wr(`PPI_ADDR_CTRL_C, 16'hffff, 4'hf);
        rdc(`PPI_ADDR_CTRL_C, mc);
        $display("test walk done");
    endtask

    // Byte strobes limit a write to its enabled half.
    task t_strobe();
        wr(`PPI_ADDR_CTRL_B, 16'h0000, 4'h1);
        wr(`PPI_ADDR_CTRL_C, 16'h0000, 4'h2);
        rdc(`PPI_ADDR_CTRL_B, mb);
        rdc(`PPI_ADDR_CTRL_C, mc);
        $display("test strobe done");
    endtask

    // Neighbouring word and the unscaled index must not reach either register.
    task t_unmapped();
        wr(`PPI_ADDR_CTRL_C + 18'h4, 16'h0000, 4'hf);
        wr(18'h1c18, 16'h0000, 4'hf);
        rdc(`PPI_ADDR_CTRL_B - 18'h4, 16'h0000);
        chk({31'h0, er}, 32'h1);
        rdc(`PPI_ADDR_CTRL_B, mb);
        rdc(`PPI_ADDR_CTRL_C, mc);
        $display("test unmapped done");
    endtask

    // A reset in mid-run restores the documented values.
    task t_midreset();
        wr(`PPI_ADDR_CTRL_B, 16'h0000, 4'hf);
        wr(`PPI_ADDR_CTRL_C, 16'h0000, 4'hf);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        mb = 16'h603f;
        mc = 16'hfffc;
        t_reset();
        $display("test midreset done");
    endtask

    // Main sequence.
    initial
    begin
        rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 18'h0; pwdata = 32'h0; pstrb = 4'h0;
        mb = 16'h603f;
        mc = 16'hfffc;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_walk();
        t_strobe();
        t_unmapped();
        t_midreset();
        stop_test();
    end
endmodule
